/* design/dmrbo_mode_regs.sv */
// mode registers, burst sequencing and dll control of the dram
//
// Behaviour
// - on-the-fly mode: column bit 12 selects chop
// - bursts wrap inside aligned four/eight column block
// - one burst length serves reads and writes
// - bit three selects burst ordering
// - sequential reads count modulo four per nibble
// - interleaved reads use start xor beat
// - chopped read: nibble order, drivers off after
// - chopped write: start bit two, ascending nibble
// - full write always ascending columns zero-seven
// - chop and full bursts start alike
// - dll reset bit starts reset, self-clears
// - power-down dll stop selects exit time
// - read latency five to fourteen, whole clocks
// - first read data at edge n+latency
// - second register holds until rewritten or reset
// - write leveling termination choice by bit 12
// - bit zero low enables dll, then reset it
// - self refresh stops then relocks dll
`timescale 1ns/1ps
module dmrbo_mode_regs #(
   parameter int COL_W = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic cmd_mrs,
   input wire logic cmd_read,
   input wire logic cmd_write,
   input wire logic [2:0] bank_addr,
   input wire logic [15:0] addr,
   input wire logic self_refresh,
   input wire logic precharge_pd,
   output logic beat_valid,
   output logic beat_write,
   output logic [COL_W-1:0] beat_col,
   output logic drive_enable,
   output logic burst_busy,
   output logic burst_chop,
   output logic [1:0] burst_len_mode,
   output logic burst_order_select,
   output logic [3:0] read_latency_cycles,
   output logic latency_reserved,
   output logic [3:0] write_recovery_cycles,
   output logic dll_reset_bit,
   output logic powerdown_dll_keep,
   output logic slow_pd_exit,
   output logic dll_running,
   output logic dll_locked,
   output logic write_leveling,
   output logic wl_all_rtt,
   output logic wl_write_rtt_only
);
   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic chop_of(input logic [1:0] mode, input logic sel);
      case (mode)
         dmrbo_pkg::BL_FIXED4: chop_of = 1'b1;
         dmrbo_pkg::BL_OTF: chop_of = ~sel;
         default: chop_of = 1'b0;
      endcase
   endfunction : chop_of

   function automatic logic [4:0] lat_of(input logic [2:0] code, input logic ext);
      if (!ext && code != 3'h0) begin
         lat_of = {1'b0, 4'(code) + 4'h4};
      end else if (ext && code <= 3'h2) begin
         lat_of = {1'b0, 4'hc + 4'(code)};
      end else begin
         lat_of = {1'b1, dmrbo_pkg::READ_LATENCY_DEFAULT};
      end
   endfunction : lat_of

   // ---------------------------------------------------------------
   // mode registers
   // ---------------------------------------------------------------
   logic [15:0] burst_latency_mode_reg;
   logic [15:0] dll_termination_mode_reg;
   logic wr_base;
   logic wr_second;

   assign wr_base = cmd_valid & cmd_mrs & (bank_addr == dmrbo_pkg::BANK_BURST_LATENCY);
   assign wr_second = cmd_valid & cmd_mrs & (bank_addr == dmrbo_pkg::BANK_DLL_TERM);

   always_ff @(posedge clk) begin
      if (rst) begin
         burst_latency_mode_reg <= dmrbo_pkg::BURST_LATENCY_RESET;
      end else if (wr_base) begin
         burst_latency_mode_reg <= addr;
      end else begin
         burst_latency_mode_reg[dmrbo_pkg::DLL_RESET_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dll_termination_mode_reg <= dmrbo_pkg::DLL_TERM_RESET;
      end else if (wr_second) begin
         dll_termination_mode_reg <= addr;
      end
   end

   // ---------------------------------------------------------------
   // decoded settings
   // ---------------------------------------------------------------
   logic [4:0] lat_dec;
   logic [2:0] wr_code;
   logic [3:0] next_wr;
   logic dll_enable;

   assign lat_dec = lat_of(burst_latency_mode_reg[dmrbo_pkg::LAT_LSB +: 3],
                           burst_latency_mode_reg[dmrbo_pkg::LAT_EXT_BIT]);
   assign wr_code = burst_latency_mode_reg[dmrbo_pkg::WR_LSB +: 3];
   // bit zero low keeps dll enabled
   assign dll_enable = ~dll_termination_mode_reg[dmrbo_pkg::DLL_DIS_BIT];

   always_comb begin
      // unsupported codes read back as zero cycles
      case (wr_code)
         3'h1: next_wr = 4'h5;
         3'h2: next_wr = 4'h6;
         3'h3: next_wr = 4'h7;
         3'h4: next_wr = 4'h8;
         3'h5: next_wr = 4'ha;
         3'h6: next_wr = 4'hc;
         default: next_wr = 4'h0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         burst_len_mode <= dmrbo_pkg::BL_FIXED8;
         burst_order_select <= 1'b0;
         read_latency_cycles <= dmrbo_pkg::READ_LATENCY_DEFAULT;
         latency_reserved <= 1'b0;
         write_recovery_cycles <= 4'h0;
         dll_reset_bit <= 1'b0;
         powerdown_dll_keep <= 1'b0;
         slow_pd_exit <= 1'b1;
         write_leveling <= 1'b0;
         wl_all_rtt <= 1'b0;
         wl_write_rtt_only <= 1'b0;
      end else begin
         burst_len_mode <= burst_latency_mode_reg[dmrbo_pkg::BL_LSB +: 2];
         burst_order_select <= burst_latency_mode_reg[dmrbo_pkg::ORDER_BIT];
         read_latency_cycles <= lat_dec[3:0];
         latency_reserved <= lat_dec[4];
         write_recovery_cycles <= next_wr;
         dll_reset_bit <= burst_latency_mode_reg[dmrbo_pkg::DLL_RESET_BIT];
         powerdown_dll_keep <= burst_latency_mode_reg[dmrbo_pkg::DLL_KEEP_BIT];
         // exit time follows dll keep bit
         slow_pd_exit <= ~burst_latency_mode_reg[dmrbo_pkg::DLL_KEEP_BIT];
         write_leveling <= dll_termination_mode_reg[dmrbo_pkg::WLEV_BIT];
         wl_all_rtt <= dll_termination_mode_reg[dmrbo_pkg::WLEV_BIT]
                       & dll_termination_mode_reg[dmrbo_pkg::QOFF_BIT];
         wl_write_rtt_only <= dll_termination_mode_reg[dmrbo_pkg::WLEV_BIT]
                              & ~dll_termination_mode_reg[dmrbo_pkg::QOFF_BIT];
      end
   end

   // ---------------------------------------------------------------
   // dll control
   // ---------------------------------------------------------------
   logic sr_prev;
   logic [9:0] lock_cnt;
   logic dll_stopped;
   logic relock;

   // slow exit mode stops the dll in power-down
   assign dll_stopped = self_refresh
                        | (precharge_pd & ~burst_latency_mode_reg[dmrbo_pkg::DLL_KEEP_BIT]);
   assign relock = (wr_base & addr[dmrbo_pkg::DLL_RESET_BIT])
                   | (sr_prev & ~self_refresh & dll_enable);

   always_ff @(posedge clk) begin
      if (rst) begin
         sr_prev <= 1'b0;
         dll_running <= 1'b0;
      end else begin
         sr_prev <= self_refresh;
         dll_running <= dll_enable & ~dll_stopped;
      end
   end

   // lock only counts while the dll runs; leaving self refresh forces a fresh lock, a power-down stop only pauses the count
   always_ff @(posedge clk) begin
      if (rst) begin
         lock_cnt <= 10'h0;
         dll_locked <= 1'b0;
      end else if (relock || !dll_enable) begin
         lock_cnt <= dmrbo_pkg::DLL_LOCK_CYCLES;
         dll_locked <= 1'b0;
      end else if (lock_cnt != 10'h0 && !dll_stopped) begin
         // lock time counted here for status only
         lock_cnt <= lock_cnt - 10'h1;
         dll_locked <= (lock_cnt == 10'h1);
      end
   end

   // ---------------------------------------------------------------
   // burst sequencer
   // ---------------------------------------------------------------
   dmrbo_pkg::dmrbo_seq_t state;
   logic [3:0] wait_cnt;
   logic [2:0] beat;
   logic [COL_W-1:0] start_col;
   logic seq_chop;
   logic seq_write;
   logic seq_il;
   logic take;
   logic emit;
   logic [2:0] cur_beat;
   logic [2:0] col_low;
   logic beat_used;

   // new read and write commands are refused until the running burst ends
   assign take = cmd_valid & (cmd_read | cmd_write) & ~cmd_mrs
                 & (state == dmrbo_pkg::SEQ_IDLE);
   assign emit = ((state == dmrbo_pkg::SEQ_WAIT) && (wait_cnt == 4'h1))
                 || (state == dmrbo_pkg::SEQ_BURST);
   assign cur_beat = (state == dmrbo_pkg::SEQ_BURST) ? beat : 3'h0;

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= dmrbo_pkg::SEQ_IDLE;
         wait_cnt <= 4'h0;
         beat <= 3'h0;
      end else begin
         case (state)
            dmrbo_pkg::SEQ_IDLE: begin
               if (take) begin
                  // first beat at edge n plus latency
                  // same start for chop and full
                  wait_cnt <= read_latency_cycles;
                  state <= dmrbo_pkg::SEQ_WAIT;
               end
            end
            dmrbo_pkg::SEQ_WAIT: begin
               if (wait_cnt == 4'h1) begin
                  beat <= 3'h1;
                  state <= dmrbo_pkg::SEQ_BURST;
               end else begin
                  wait_cnt <= wait_cnt - 4'h1;
               end
            end
            dmrbo_pkg::SEQ_BURST: begin
               // eight slots even for a chop
               beat <= beat + 3'h1;
               if (beat == dmrbo_pkg::LAST_BEAT) begin
                  state <= dmrbo_pkg::SEQ_IDLE;
               end
            end
            default: state <= dmrbo_pkg::SEQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         start_col <= '0;
         seq_chop <= 1'b0;
         seq_write <= 1'b0;
         seq_il <= 1'b0;
      end else if (take) begin
         start_col <= addr[COL_W-1:0];
         seq_chop <= chop_of(burst_latency_mode_reg[dmrbo_pkg::BL_LSB +: 2],
                             addr[dmrbo_pkg::CHOP_ADDR_BIT]);
         seq_write <= cmd_write;
         seq_il <= burst_latency_mode_reg[dmrbo_pkg::ORDER_BIT];
      end
   end

   dmrbo_burst_order u_order (
      .start_low(start_col[2:0]),
      .beat(cur_beat),
      .interleave(seq_il),
      .chop(seq_chop),
      .write(seq_write),
      .col_low(col_low),
      .beat_used(beat_used)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         beat_valid <= 1'b0;
         beat_write <= 1'b0;
         beat_col <= '0;
         drive_enable <= 1'b0;
         burst_busy <= 1'b0;
         burst_chop <= 1'b0;
      end else begin
         beat_valid <= emit & beat_used;
         beat_write <= emit & seq_write;
         // upper column bits fix the block
         beat_col <= {start_col[COL_W-1:3], col_low};
         drive_enable <= emit & beat_used & ~seq_write;
         burst_busy <= take | (state == dmrbo_pkg::SEQ_WAIT)
                       | ((state == dmrbo_pkg::SEQ_BURST) && (beat != dmrbo_pkg::LAST_BEAT));
         burst_chop <= take ? chop_of(burst_latency_mode_reg[dmrbo_pkg::BL_LSB +: 2],
                                      addr[dmrbo_pkg::CHOP_ADDR_BIT]) : seq_chop;
      end
   end
endmodule : dmrbo_mode_regs

/* design/dmrbo_pkg.sv */
// shared constants and types for the mode register and burst order block
package dmrbo_pkg;
   // ---------------------------------------------------------------
   // command targets (bank address of a mode set)
   // ---------------------------------------------------------------
   localparam logic [2:0] BANK_BURST_LATENCY = 3'h0;
   localparam logic [2:0] BANK_DLL_TERM = 3'h1;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] BURST_LATENCY_RESET = 16'h0000;
   localparam logic [15:0] DLL_TERM_RESET = 16'h0000;

   // ---------------------------------------------------------------
   // burst_latency_mode_reg fields
   // ---------------------------------------------------------------
   localparam int BL_LSB = 0;
   localparam int LAT_EXT_BIT = 2;
   localparam int ORDER_BIT = 3;
   localparam int LAT_LSB = 4;
   localparam int DLL_RESET_BIT = 8;
   localparam int WR_LSB = 9;
   localparam int DLL_KEEP_BIT = 12;

   // ---------------------------------------------------------------
   // dll_termination_mode_reg fields
   // ---------------------------------------------------------------
   localparam int DLL_DIS_BIT = 0;
   localparam int WLEV_BIT = 7;
   localparam int QOFF_BIT = 12;

   // ---------------------------------------------------------------
   // burst length codes and address bits
   // ---------------------------------------------------------------
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_FIXED4 = 2'h2;
   localparam int CHOP_ADDR_BIT = 12;

   // ---------------------------------------------------------------
   // timing counts
   // ---------------------------------------------------------------
   localparam logic [9:0] DLL_LOCK_CYCLES = 10'h200;
   localparam logic [3:0] READ_LATENCY_DEFAULT = 4'h5;
   localparam logic [2:0] LAST_BEAT = 3'h7;

   // ---------------------------------------------------------------
   // burst sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_WAIT = 3'b010,
      SEQ_BURST = 3'b100
   } dmrbo_seq_t;
endpackage : dmrbo_pkg

/* design/dmrbo_burst_order.sv */
// column order inside one aligned burst block
`timescale 1ns/1ps
module dmrbo_burst_order (
   input wire logic [2:0] start_low,
   input wire logic [2:0] beat,
   input wire logic interleave,
   input wire logic chop,
   input wire logic write,
   output logic [2:0] col_low,
   output logic beat_used
);
   logic [1:0] off;

   always_comb begin
      if (interleave) begin
         off = start_low[1:0] ^ beat[1:0];
      end else begin
         off = start_low[1:0] + beat[1:0];
      end
      if (write) begin
         col_low = chop ? {start_low[2], beat[1:0]} : beat;
      end else begin
         col_low = {start_low[2] ^ (beat[2] & ~chop), off};
      end
      // last four slots of a chop are unused
      beat_used = ~(chop & beat[2]);
   end
endmodule : dmrbo_burst_order

/* tb/dmrbo_mode_regs_monitor.sv */
// assertion checker for the mode register and burst block
`timescale 1ns/1ps
module dmrbo_mode_regs_monitor #(
   parameter int COL_W = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic cmd_mrs,
   input wire logic cmd_read,
   input wire logic cmd_write,
   input wire logic [2:0] bank_addr,
   input wire logic [15:0] addr,
   input wire logic beat_valid,
   input wire logic beat_write,
   input wire logic [COL_W-1:0] beat_col,
   input wire logic drive_enable,
   input wire logic burst_busy,
   input wire logic burst_chop,
   input wire logic burst_order_select,
   input wire logic [3:0] read_latency_cycles,
   input wire logic dll_reset_bit,
   input wire logic powerdown_dll_keep,
   input wire logic slow_pd_exit,
   input wire logic write_leveling,
   input wire logic wl_all_rtt,
   input wire logic wl_write_rtt_only
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire mrs0 = cmd_valid && cmd_mrs && bank_addr == 3'h0;
   wire mrs1 = cmd_valid && cmd_mrs && bank_addr == 3'h1;
   wire take = cmd_valid && !cmd_mrs && (cmd_read || cmd_write) && !burst_busy;
   wire slot = beat_valid || beat_write;
   logic [4:0] since;
   // saturates so a long idle gap never wraps back into range
   always_ff @(posedge clk) begin
      if (rst) since <= 5'h0;
      else if (take) since <= 5'h1;
      else if (since != 5'h0 && since != 5'h1f) since <= since + 5'h1;
   end
   sequence full_read_s; (beat_valid && drive_enable && !beat_write) [*8]; endsequence
   sequence chop_read_s;
      (beat_valid && drive_enable) [*4] ##1 (!beat_valid && !drive_enable) [*4];
   endsequence
   sequence write_s; (beat_write && !drive_enable) [*8]; endsequence
   AST_LATENCY: assert property (
      $rose(slot) |-> since == 5'(read_latency_cycles) + 5'h1)
      else $error("first slot off latency");
   AST_READ8: assert property (
      $rose(beat_valid) && !beat_write && !burst_chop |-> full_read_s ##1 !slot)
      else $error("full read slots wrong");
   AST_CHOP_READ: assert property (
      $rose(beat_valid) && !beat_write && burst_chop |-> chop_read_s)
      else $error("chop read slots wrong");
   AST_WRITE: assert property ($rose(beat_write) |-> write_s ##1 !beat_write)
      else $error("write slots wrong");
   AST_BLOCK: assert property (
      beat_valid && $past(beat_valid) |-> beat_col[COL_W-1:3] == $past(beat_col[COL_W-1:3])
         && (!burst_chop || beat_col[2] == $past(beat_col[2])))
      else $error("burst left its block");
   AST_WR_ASC: assert property (
      beat_write && beat_valid && $past(beat_valid)
         |-> beat_col[2:0] == $past(beat_col[2:0]) + 3'h1)
      else $error("write not ascending");
   AST_WR_START: assert property (
      $rose(beat_write) |-> beat_col[1:0] == 2'h0 && (burst_chop || !beat_col[2]))
      else $error("write start column");
   AST_DLL_CLEAR: assert property (
      mrs0 && addr[8] |-> ##2 dll_reset_bit ##1 !dll_reset_bit)
      else $error("dll reset bit not self clearing");
   AST_BASE_FIELDS: assert property (
      mrs0 |-> ##2 burst_order_select == $past(addr[3], 2)
         && powerdown_dll_keep == $past(addr[12], 2))
      else $error("base register field decode");
   AST_EXIT_TIME: assert property (slow_pd_exit == !powerdown_dll_keep)
      else $error("exit time select");
   AST_WL: assert property (
      mrs1 |-> ##2 wl_all_rtt == ($past(addr[7], 2) && $past(addr[12], 2))
         && wl_write_rtt_only == ($past(addr[7], 2) && !$past(addr[12], 2)))
      else $error("leveling termination decode");
   AST_HOLD: assert property (!$past(mrs1, 2) |-> $stable(write_leveling))
      else $error("second register changed unwritten");
   AST_LAT_RANGE: assert property (
      read_latency_cycles >= 4'h5 && read_latency_cycles <= 4'he)
      else $error("latency out of range");
endmodule : dmrbo_mode_regs_monitor
bind dmrbo_mode_regs dmrbo_mode_regs_monitor #(.COL_W(COL_W)) u_mon (.clk, .rst, .cmd_valid,
   .cmd_mrs, .cmd_read, .cmd_write, .bank_addr, .addr, .beat_valid, .beat_write, .beat_col,
   .drive_enable, .burst_busy, .burst_chop, .burst_order_select, .read_latency_cycles,
   .dll_reset_bit, .powerdown_dll_keep, .slow_pd_exit, .write_leveling, .wl_all_rtt,
   .wl_write_rtt_only);

/* tb/dmrbo_ctrl_model.sv */
// memory controller model driving the command bus
`timescale 1ns/1ps
module dmrbo_ctrl_model #(
   parameter int MOD_DELAY = 12
) (
   input wire logic clk,
   input wire logic burst_busy,
   output logic cmd_valid,
   output logic cmd_mrs,
   output logic cmd_read,
   output logic cmd_write,
   output logic [2:0] bank_addr,
   output logic [15:0] addr
);
   int edges = 0;
   int dll_at = 0;
   initial begin
      cmd_valid = 1'b0;
      cmd_mrs = 1'b0;
      cmd_read = 1'b0;
      cmd_write = 1'b0;
      bank_addr = 3'h0;
      addr = 16'h0;
   end
   always @(posedge clk) edges <= edges + 1;
   task automatic drive(input logic m, r, w, input logic [2:0] ba, input logic [15:0] a);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_mrs <= m;
      cmd_read <= r;
      cmd_write <= w;
      bank_addr <= ba;
      addr <= a;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_mrs <= 1'b0;
      cmd_read <= 1'b0;
      cmd_write <= 1'b0;
      // released lines show the inverse so a stale value never passes
      bank_addr <= ~ba;
      addr <= ~a;
   endtask : drive
   task automatic mrs(input logic [2:0] ba, input logic [15:0] a);
      while (burst_busy) @(posedge clk);
      drive(1'b1, 1'b0, 1'b0, ba, a & (ba == 3'h1 ? 16'h1aff : ba == 3'h0 ? 16'h1f7f : 16'hffff));
      if (ba == 3'h0 && a[8]) dll_at = edges;
      repeat (MOD_DELAY) @(posedge clk);
   endtask : mrs
   task automatic rw(input logic wr, input logic [15:0] a);
      while (!wr && edges - dll_at < 512) @(posedge clk);
      drive(1'b0, !wr, wr, 3'h0, a);
   endtask : rw
endmodule : dmrbo_ctrl_model

/* tb/dmrbo_mode_regs_bench.sv */
// self-checking bench for the mode register and burst block
`timescale 1ns/1ps
module dmrbo_mode_regs_bench;
   localparam int COL_W = 10;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic self_refresh = 1'b0;
   logic precharge_pd = 1'b0;
   logic cmd_valid, cmd_mrs, cmd_read, cmd_write;
   logic [2:0] bank_addr;
   logic [15:0] addr;
   logic beat_valid, beat_write, drive_enable, burst_busy, burst_chop, burst_order_select;
   logic [COL_W-1:0] beat_col;
   logic [1:0] burst_len_mode;
   logic [3:0] read_latency_cycles, write_recovery_cycles;
   logic latency_reserved, dll_reset_bit, powerdown_dll_keep, slow_pd_exit;
   logic dll_running, dll_locked, write_leveling, wl_all_rtt, wl_write_rtt_only;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   always #20 clk = ~clk;
   dmrbo_ctrl_model ctrl (.clk, .burst_busy, .cmd_valid, .cmd_mrs, .cmd_read, .cmd_write,
      .bank_addr, .addr);
   dmrbo_mode_regs #(.COL_W(COL_W)) dut (.clk, .rst, .cmd_valid, .cmd_mrs, .cmd_read,
      .cmd_write, .bank_addr, .addr, .self_refresh, .precharge_pd, .beat_valid, .beat_write,
      .beat_col, .drive_enable, .burst_busy, .burst_chop, .burst_len_mode, .burst_order_select,
      .read_latency_cycles, .latency_reserved, .write_recovery_cycles, .dll_reset_bit,
      .powerdown_dll_keep, .slow_pd_exit, .dll_running, .dll_locked, .write_leveling,
      .wl_all_rtt, .wl_write_rtt_only);
   task automatic finish_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   // ceiling well above the few thousand cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         failures++;
         finish_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   function automatic logic [2:0] exp_low(logic [2:0] s, logic [2:0] i, logic il, logic ch,
      logic wr);
      if (wr) return ch ? {s[2], i[1:0]} : i;
      if (il) return ch ? {s[2], s[1:0] ^ i[1:0]} : s ^ i;
      return {ch ? s[2] : s[2] ^ i[2], s[1:0] + i[1:0]};
   endfunction : exp_low
   function automatic logic [3:0] exp_lat(logic b2, logic [2:0] c);
      if (!b2 && c != 3'h0) return {1'b0, c} + 4'h4;
      if (b2 && c < 3'h3) return {1'b0, c} + 4'hc;
      return 4'h5;
   endfunction : exp_lat
   function automatic logic [3:0] exp_wr(logic [2:0] c);
      if (c == 3'h0 || c == 3'h7) return 4'h0;
      return (c < 3'h5) ? {1'b0, c} + 4'h4 : {c, 1'b0};
   endfunction : exp_wr
   task automatic chk_slot(input logic [2:0] i, input logic wr, ch, il,
      input logic [COL_W-1:0] s);
      logic [COL_W-1:0] col;
      logic used;
      used = !(ch && i[2]);
      col = {s[COL_W-1:3], exp_low(s[2:0], i, il, ch, wr)};
      compares++;
      if ({beat_valid, beat_write, drive_enable} !== {used, wr, used && !wr} ||
         (used && beat_col !== col)) begin
         failures++;
         $display("[FAIL] %0t slot %0d col %h exp %h", $time, i, beat_col, col);
      end
   endtask : chk_slot
   task automatic burst(input logic wr, input logic [15:0] a, input logic [1:0] bl,
      input logic il, input logic [3:0] lat);
      logic ch;
      int k;
      ch = (bl == 2'h2) || (bl == 2'h1 && !a[12]);
      ctrl.rw(wr, a);
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (!(beat_valid || beat_write) && k < 20);
      chk(16'(k), {12'h0, lat}, "latency");
      for (int i = 0; i < 8; i++) begin
         if (i > 0) @(posedge clk);
         #1;
         chk_slot(3'(i), wr, ch, il, a[COL_W-1:0]);
      end
      @(posedge clk);
      #1;
      chk({15'h0, burst_busy | beat_valid | beat_write}, 16'h0, "burst end");
   endtask : burst
   initial begin
      logic [15:0] m;
      logic [15:0] a;
      logic [1:0] bl;
      logic [2:0] c;
      logic b2;
      void'($urandom(32'hcb43ccef));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk({12'h0, read_latency_cycles}, 16'h5, "reset latency");
      chk({14'h0, slow_pd_exit, dll_locked}, 16'h2, "reset state");
      ctrl.mrs(3'h0, 16'h0100);
      repeat (495) @(posedge clk);
      #1;
      chk({14'h0, dll_reset_bit, dll_locked}, 16'h0, "lock early");
      repeat (10) @(posedge clk);
      chk({15'h0, dll_locked}, 16'h1, "lock");
      self_refresh <= 1'b1;
      repeat (4) @(posedge clk);
      chk({15'h0, dll_running}, 16'h0, "self refresh");
      self_refresh <= 1'b0;
      repeat (4) @(posedge clk);
      chk({14'h0, dll_running, dll_locked}, 16'h2, "relock start");
      repeat (520) @(posedge clk);
      chk({15'h0, dll_locked}, 16'h1, "relock");
      for (int p = 0; p < 2; p++) begin
         ctrl.mrs(3'h0, {3'h0, p[0], 12'h0});
         precharge_pd <= 1'b1;
         repeat (4) @(posedge clk);
         #1;
         chk({14'h0, dll_running, slow_pd_exit}, {14'h0, p[0], !p[0]}, "powerdown");
         precharge_pd <= 1'b0;
      end
      $display("test dll done");
      for (int w = 0; w < 4; w++) begin
         ctrl.mrs(3'h1, {3'h0, w[1], 4'h0, w[0], 6'h0, w[1] ^ w[0]});
         chk({12'h0, write_leveling, wl_all_rtt, wl_write_rtt_only, dll_running},
            {12'h0, w[0], w[0] & w[1], w[0] & !w[1], !(w[1] ^ w[0])}, "second reg");
      end
      ctrl.mrs(3'h0, 16'h0100);
      for (int b = 2; b < 8; b++) ctrl.mrs(3'(b), 16'hffff);
      chk({11'h0, write_leveling, wl_all_rtt, dll_running, burst_order_select,
         latency_reserved}, 16'h1d, "bank ignore");
      ctrl.mrs(3'h1, 16'h0000);
      $display("test registers done");
      for (int t = 0; t < 12; t++) begin
         // code three must behave as fixed eight
         bl = 2'(t % 4);
         b2 = 1'($urandom_range(1));
         c = b2 ? 3'($urandom_range(2)) : 3'($urandom_range(7, 1));
         m = {3'h0, 1'($urandom_range(1)), 3'($urandom_range(6, 1)), 2'h0, c, t[2], b2, bl};
         ctrl.mrs(3'h0, m);
         chk({read_latency_cycles, write_recovery_cycles, latency_reserved, burst_order_select,
            powerdown_dll_keep, 3'h0, burst_len_mode}, {exp_lat(b2, c), exp_wr(m[11:9]),
            1'b0, m[3], m[12], 3'h0, bl}, "base reg");
         for (int i = 0; i < 6; i++) begin
            a = 16'($urandom) & 16'h13ff;
            if (i == 0) a[9:0] = 10'h3ff;
            burst(1'($urandom_range(1)), a, bl, m[3], exp_lat(b2, c));
         end
         $display("test config %0d done", t);
      end
      finish_test();
   end
endmodule : dmrbo_mode_regs_bench
